// *** dv/network_service_mailbox_commands_tb.sv ***
// random bench of the mailbox command decoder
// assumes the decoder, its checker and the response sink
`timescale 1ns/1ps
`include "nsm_regs.svh"

module network_service_mailbox_commands_tb;
  logic clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready;
  logic web_server_en, ftp_server_en, global_admin, smtp_name_override;
  logic [15:0] cmd_word, rsp_word, smtp_name_size, name_rd_word;
  logic [31:0] smtp_ip_in;
  logic [5:0] name_rd_idx;
  logic [15:0] dq[$], eq[$];
  int miscompares = 0, check_count = 0, len, k;

  nsm_mbox_decoder dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_last(rsp_last),
    .rsp_ready(rsp_ready), .smtp_ip_in(smtp_ip_in), .web_server_en(web_server_en),
    .ftp_server_en(ftp_server_en), .global_admin(global_admin), .smtp_name_override(smtp_name_override),
    .smtp_name_size(smtp_name_size), .name_rd_idx(name_rd_idx), .name_rd_word(name_rd_word));
  nsm_rsp_sink sink (.clk(clk), .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_last(rsp_last),
    .rsp_ready(rsp_ready));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] hdr_exp(int i, logic [15:0] id, rinfo, code, rsz);
    case (i)
      0: return id;
      1: return rinfo;
      2: return code;
      3: return rsz;
      4, 5: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction

  // one command word, offered at a falling edge while ready
  task put(input logic [15:0] w);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 200)
    begin
      miscompares++;
      complete_run;
    end
    cmd_valid = 1'b1;
    cmd_word = w;
    @(negedge clk);
  endtask

  // whole command from dq, then compare the response with eq
  task run(input logic [15:0] cinfo, code, size, rinfo, rsz);
    int n, f;
    logic [15:0] id;
    id = 16'($urandom);
    f = sink.frames;
    put(id);
    put(cinfo);
    put(code);
    put(size);
    put(16'h0001);
    put(16'h0001);
    put(16'h0000);
    put(16'h0000);
    repeat (8) put(16'($urandom));
    foreach (dq[i]) put(dq[i]);
    cmd_valid = 1'b0;
    n = 0;
    while (sink.frames == f && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 500)
    begin
      miscompares++;
      complete_run;
    end
    check(16'(sink.q.size()), 16'(16 + eq.size()));
    for (int i = 0; i < 16; i++) check(sink.q[i], hdr_exp(i, id, rinfo, code, rsz));
    foreach (eq[i]) check(sink.q[16 + i], eq[i]);
    sink.q.delete();
  endtask

  initial
  begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    smtp_ip_in = 32'h0;
    name_rd_idx = 6'h00;
    void'($urandom(81));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check(16'({web_server_en, ftp_server_en, global_admin, smtp_name_override}), 16'h000c);
    run(16'h4003, `NSM_CMD_WEB_OFF, 16'h0, `NSM_INFO_ERR, 16'h0);
    check(16'(web_server_en), 16'h1);
    run(`NSM_INFO_CMD, `NSM_CMD_WEB_OFF, 16'h0, `NSM_INFO_RSP, 16'h0);
    check(16'(web_server_en), 16'h0);
    // unknown code and data on a no-data command are refused, data still consumed
    run(`NSM_INFO_CMD, 16'h0011, 16'h0, `NSM_INFO_ERR, 16'h0);
    dq = '{16'h1234};
    run(`NSM_INFO_CMD, `NSM_CMD_WEB_ON, 16'h2, `NSM_INFO_ERR, 16'h0);
    dq.delete();
    check(16'(web_server_en), 16'h0);
    run(`NSM_INFO_CMD, `NSM_CMD_WEB_ON, 16'h0, `NSM_INFO_RSP, 16'h0);
    check(16'(web_server_en), 16'h1);
    run(`NSM_INFO_CMD, `NSM_CMD_FTP_OFF, 16'h0, `NSM_INFO_RSP, 16'h0);
    check(16'(ftp_server_en), 16'h0);
    // issued after the web and ftp commands, well after reset
    run(`NSM_INFO_CMD, `NSM_CMD_ADMIN, 16'h0, `NSM_INFO_RSP, 16'h0);
    check(16'(global_admin), 16'h1);
    repeat (4)
    begin
      smtp_ip_in = $urandom;
      eq = '{smtp_ip_in[31:16], smtp_ip_in[15:0]};
      run(`NSM_INFO_CMD, `NSM_CMD_SMTP_GET, 16'h0, `NSM_INFO_RSP, `NSM_SIZE_IP);
      eq.delete();
    end
    for (int r = 0; r < 5; r++)
    begin
      // printable text ending in a zero byte, first one at full capacity
      len = (r == 0) ? 128 : 1 + $urandom % 127;
      for (int i = 0; i < (len + 1) / 2; i++) dq.push_back({8'h41 + 8'($urandom % 26), 8'h61});
      dq[$] = (len % 2) ? 16'h0000 : {dq[$][15:8], 8'h00};
      eq = dq;
      run(`NSM_INFO_CMD, `NSM_CMD_SMTP_NAME, 16'(len), `NSM_INFO_RSP, 16'(len));
      check(16'(smtp_name_override), 16'h1);
      check(smtp_name_size, 16'(len));
      k = $urandom % dq.size();
      name_rd_idx = 6'(k);
      @(negedge clk);
      check(name_rd_word, dq[k]);
      dq.delete();
      eq.delete();
    end
    complete_run;
  end
endmodule

// *** dv/nsm_mbox_checker.sv ***
// port checker of the mailbox command decoder
// assumes it is bound to nsm_mbox_decoder, one clock domain
`timescale 1ns/1ps
`include "nsm_regs.svh"

module nsm_mbox_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_word,
  input wire logic rsp_last,
  input wire logic rsp_ready,
  input wire logic web_server_en,
  input wire logic ftp_server_en,
  input wire logic global_admin
);
  logic [7:0] idx_r;
  wire take = rsp_valid && rsp_ready;

  // position of the response word on offer
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      idx_r <= 8'h00;
    else if (take)
      idx_r <= rsp_last ? 8'h00 : idx_r + 8'h01;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_busy_refuse: assert property (rsp_valid |-> !cmd_ready)
    else $error("command taken during response");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_word) && $stable(rsp_last))
    else $error("response word not held");
  a_rsp_info: assert property (rsp_valid && idx_r == 8'h01 |-> rsp_word inside {`NSM_INFO_RSP, `NSM_INFO_ERR})
    else $error("bad response info word");
  a_rsp_frames: assert property (rsp_valid && (idx_r == 8'h04 || idx_r == 8'h05) |-> rsp_word == 16'h0001)
    else $error("bad frame word");
  a_rsp_zeros: assert property (rsp_valid && idx_r >= 8'h06 && idx_r <= 8'h0f |-> rsp_word == 16'h0000)
    else $error("offset or extended word not zero");
  a_last_frees: assert property (take && rsp_last |=> !rsp_valid && cmd_ready)
    else $error("channel not freed after last word");
  a_web_cause: assert property ($changed(web_server_en) |-> ##[0:3] rsp_valid)
    else $error("web enable moved without a command");
  a_ftp_sticky: assert property (!ftp_server_en |=> !ftp_server_en)
    else $error("ftp server came back");
  a_admin_sticky: assert property (global_admin |=> global_admin)
    else $error("admin mode left");

  c_frame: cover property (take && rsp_last);
  c_web_off: cover property ($fell(web_server_en));
  c_admin: cover property ($rose(global_admin));
endmodule

bind nsm_mbox_decoder nsm_mbox_checker u_chk (.clk(clk), .rst_n(rst_n), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
  .web_server_en(web_server_en), .ftp_server_en(ftp_server_en), .global_admin(global_admin));

// *** dv/nsm_rsp_sink.sv ***
// response sink standing for the host side of the mailbox
// assumes words are taken on rising clk edges
`timescale 1ns/1ps

module nsm_rsp_sink (
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_word,
  input wire logic rsp_last,
  output logic rsp_ready
);
  logic [15:0] q[$];
  int frames = 0;

  // random stalls so that words must hold
  initial
    rsp_ready = 1'b0;
  always @(negedge clk)
    rsp_ready <= ($urandom % 3) != 0;
  always @(posedge clk)
    if (rsp_valid && rsp_ready)
    begin
      q.push_back(rsp_word);
      if (rsp_last)
        frames++;
    end
endmodule

// *** verilog/nsm_mbox_decoder.sv ***
// mailbox command decoder for the network-service settings
// assumes command and response words come from logic on clk, one word per handshake
`timescale 1ns/1ps
`include "nsm_regs.svh"

// Notes on behaviour
// - code 0016h sets mail server by text; data size gives text length
// - name response returns the same size and an unchanged copy of the text
// - a name given by command overrides the stored configuration server value
// - code 000Fh answers size 0004h with server ip, upper word first
// - code 0004h turns the web server off, no data either way
// - web server is on from reset until a web command changes it
// - code 0005h turns the web server on, no data either way
// - code 0006h turns the ftp server off, no data either way
// - code 000Bh enters global administrator mode for user accounts
module nsm_mbox_decoder #(
  parameter int TEXT_WORDS = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_word,
  output logic rsp_last,
  input wire logic rsp_ready,
  input wire logic [31:0] smtp_ip_in,
  output logic web_server_en,
  output logic ftp_server_en,
  output logic global_admin,
  output logic smtp_name_override,
  output logic [15:0] smtp_name_size,
  input wire logic [$clog2(TEXT_WORDS)-1:0] name_rd_idx,
  output logic [15:0] name_rd_word
);

  localparam int AW = $clog2(TEXT_WORDS);
  localparam logic [16:0] TEXT_CAP = 17'(TEXT_WORDS);

  // words of message data for a given byte count, rounded up
  function automatic logic [16:0] nsm_words(input logic [15:0] size);
    logic [16:0] s;
    s = {1'b0, size} + 17'h00001;
    return {1'b0, s[16:1]};
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // state and captured header
  // ----------------------------------------------------------------
  nsm_pkg::nsm_state_t state_r;
  nsm_pkg::nsm_state_t state_nxt;
  logic [15:0] idx_r;
  logic [15:0] id_r;
  logic [15:0] info_r;
  logic [15:0] code_r;
  logic [15:0] size_r;
  logic [15:0] fc_r;
  logic [15:0] fn_r;
  logic [15:0] offh_r;
  logic [15:0] offl_r;
  logic [15:0] rsp_info_r;
  logic [15:0] rsp_size_r;
  logic [15:0] last_idx_r;
  logic [31:0] ip_r;
  logic cmd_ready_r;
  logic rsp_valid_r;
  logic [15:0] rsp_word_r;
  logic rsp_last_r;
  logic web_en_r;
  logic ftp_en_r;
  logic admin_r;
  logic override_r;
  logic [15:0] name_size_r;
  logic [15:0] name_rd_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire take = cmd_valid && cmd_ready_r;
  wire give = rsp_valid_r && rsp_ready;
  wire [16:0] cmd_words = nsm_words(size_r);
  wire [15:0] dix = idx_r - `NSM_HDR_LEN;
  wire hdr_end = idx_r == (`NSM_HDR_LEN - 16'h0001);
  wire data_end = {1'b0, dix} == (cmd_words - 17'h00001);
  wire is_name = code_r == `NSM_CMD_SMTP_NAME;
  wire is_get = code_r == `NSM_CMD_SMTP_GET;
  wire name_fits = (cmd_words <= TEXT_CAP) && (size_r != 16'h0000);
  wire hdr_ok = (info_r == `NSM_INFO_CMD) && (fc_r == `NSM_FRAME_ONE) && (fn_r == `NSM_FRAME_ONE)
    && (offh_r == `NSM_ZERO_WORD) && (offl_r == `NSM_ZERO_WORD);
  wire known = (code_r == `NSM_CMD_WEB_OFF) || (code_r == `NSM_CMD_WEB_ON) || (code_r == `NSM_CMD_FTP_OFF)
    || (code_r == `NSM_CMD_ADMIN) || is_get;
  wire cmd_ok = hdr_ok && (is_name ? name_fits : (known && size_r == `NSM_ZERO_WORD));
  wire buf_wr = (state_r == nsm_pkg::NSM_S_DATA) && take && is_name && ({1'b0, dix} < TEXT_CAP);
  wire [15:0] buf_rd_data;
  wire [15:0] buf_rd2_data;
  wire [15:0] rsp_size_nxt = !cmd_ok ? `NSM_ZERO_WORD : is_name ? size_r
    : is_get ? `NSM_SIZE_IP : `NSM_ZERO_WORD;
  wire [16:0] rsp_data_words = nsm_words(rsp_size_nxt);

  // response word at the current index
  wire [15:0] hdr_word = (idx_r == `NSM_POS_ID) ? id_r
    : (idx_r == `NSM_POS_INFO) ? rsp_info_r
    : (idx_r == `NSM_POS_CMD) ? code_r
    : (idx_r == `NSM_POS_SIZE) ? rsp_size_r
    : (idx_r == `NSM_POS_FC || idx_r == `NSM_POS_FN) ? `NSM_FRAME_ONE
    : `NSM_ZERO_WORD;
  wire [15:0] data_word = is_get ? ((dix == 16'h0000) ? ip_r[31:16] : ip_r[15:0])
    : buf_rd_data;
  wire [15:0] next_word = (idx_r < `NSM_HDR_LEN) ? hdr_word : data_word;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      nsm_pkg::NSM_S_HDR:
      begin
        if (take && hdr_end)
        begin
          state_nxt = (cmd_words == 17'h00000) ? nsm_pkg::NSM_S_EXEC : nsm_pkg::NSM_S_DATA;
        end
      end
      nsm_pkg::NSM_S_DATA:
      begin
        if (take && data_end)
        begin
          state_nxt = nsm_pkg::NSM_S_EXEC;
        end
      end
      nsm_pkg::NSM_S_EXEC:
      begin
        state_nxt = nsm_pkg::NSM_S_RSP;
      end
      nsm_pkg::NSM_S_RSP:
      begin
        if (give && rsp_last_r)
        begin
          state_nxt = nsm_pkg::NSM_S_HDR;
        end
      end
      default:
      begin
        state_nxt = nsm_pkg::NSM_S_HDR;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing and header capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      state_r <= nsm_pkg::NSM_S_HDR;
      cmd_ready_r <= 1'b0;
      idx_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      cmd_ready_r <= (state_nxt == nsm_pkg::NSM_S_HDR) || (state_nxt == nsm_pkg::NSM_S_DATA);
      // the index moves on as each response word is loaded, so the first load must see index zero
      if (take || (state_r == nsm_pkg::NSM_S_RSP && !rsp_valid_r) || (give && !rsp_last_r))
      begin
        idx_r <= idx_r + 16'h0001;
      end
      else if (state_nxt == nsm_pkg::NSM_S_HDR && state_r == nsm_pkg::NSM_S_RSP)
      begin
        idx_r <= 16'h0000;
      end
      if (take && hdr_end && cmd_words == 17'h00000)
      begin
        idx_r <= 16'h0000;
      end
      else if (take && state_r == nsm_pkg::NSM_S_DATA && data_end)
      begin
        idx_r <= 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      id_r <= 16'h0000;
      info_r <= 16'h0000;
      code_r <= 16'h0000;
      size_r <= 16'h0000;
      fc_r <= 16'h0000;
      fn_r <= 16'h0000;
      offh_r <= 16'h0000;
      offl_r <= 16'h0000;
    end
    else if (take && state_r == nsm_pkg::NSM_S_HDR)
    begin
      id_r <= (idx_r == `NSM_POS_ID) ? cmd_word : id_r;
      info_r <= (idx_r == `NSM_POS_INFO) ? cmd_word : info_r;
      code_r <= (idx_r == `NSM_POS_CMD) ? cmd_word : code_r;
      size_r <= (idx_r == `NSM_POS_SIZE) ? cmd_word : size_r;
      fc_r <= (idx_r == `NSM_POS_FC) ? cmd_word : fc_r;
      fn_r <= (idx_r == `NSM_POS_FN) ? cmd_word : fn_r;
      offh_r <= (idx_r == `NSM_POS_OFFH) ? cmd_word : offh_r;
      offl_r <= (idx_r == `NSM_POS_OFFL) ? cmd_word : offl_r;
    end
  end

  // ----------------------------------------------------------------
  // command effects
  // ----------------------------------------------------------------
  wire exec_ok = (state_r == nsm_pkg::NSM_S_EXEC) && cmd_ok;

  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      web_en_r <= 1'b1;
      ftp_en_r <= 1'b1;
      admin_r <= 1'b0;
      override_r <= 1'b0;
      name_size_r <= 16'h0000;
      ip_r <= 32'h00000000;
      rsp_info_r <= `NSM_INFO_RSP;
      rsp_size_r <= 16'h0000;
      last_idx_r <= 16'h0000;
    end
    else if (state_r == nsm_pkg::NSM_S_EXEC)
    begin
      web_en_r <= (exec_ok && code_r == `NSM_CMD_WEB_OFF) ? 1'b0
        : (exec_ok && code_r == `NSM_CMD_WEB_ON) ? 1'b1 : web_en_r;
      ftp_en_r <= (exec_ok && code_r == `NSM_CMD_FTP_OFF) ? 1'b0 : ftp_en_r;
      admin_r <= (exec_ok && code_r == `NSM_CMD_ADMIN) ? 1'b1 : admin_r;
      override_r <= (exec_ok && is_name) ? 1'b1 : override_r;
      name_size_r <= (exec_ok && is_name) ? size_r : name_size_r;
      ip_r <= smtp_ip_in;
      rsp_info_r <= cmd_ok ? `NSM_INFO_RSP : `NSM_INFO_ERR;
      rsp_size_r <= rsp_size_nxt;
      last_idx_r <= `NSM_HDR_LEN - 16'h0001 + rsp_data_words[15:0];
    end
  end

  // ----------------------------------------------------------------
  // response output
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      rsp_valid_r <= 1'b0;
      rsp_word_r <= 16'h0000;
      rsp_last_r <= 1'b0;
      name_rd_r <= 16'h0000;
    end
    else
    begin
      name_rd_r <= buf_rd2_data;
      if ((state_r == nsm_pkg::NSM_S_RSP && !rsp_valid_r) || (give && !rsp_last_r))
      begin
        rsp_valid_r <= 1'b1;
        rsp_word_r <= next_word;
        rsp_last_r <= idx_r == last_idx_r;
      end
      else if (give)
      begin
        rsp_valid_r <= 1'b0;
        rsp_last_r <= 1'b0;
      end
    end
  end

  nsm_text_buf #(
    .WORDS(TEXT_WORDS)
  ) u_text (
    .clk(clk),
    .rst_n(rst_sync_r),
    .wr_en(buf_wr),
    .wr_idx(dix[AW-1:0]),
    .wr_data(cmd_word),
    .rd_idx(dix[AW-1:0]),
    .rd_data(buf_rd_data),
    .rd2_idx(name_rd_idx),
    .rd2_data(buf_rd2_data)
  );

  assign cmd_ready = cmd_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_word = rsp_word_r;
  assign rsp_last = rsp_last_r;
  assign web_server_en = web_en_r;
  assign ftp_server_en = ftp_en_r;
  assign global_admin = admin_r;
  assign smtp_name_override = override_r;
  assign smtp_name_size = name_size_r;
  assign name_rd_word = name_rd_r;

endmodule

// *** verilog/nsm_pkg.sv ***
// types of the network-service mailbox command decoder
// assumes nothing beyond the decoder itself
package nsm_pkg;

  // ----------------------------------------------------------------
  // decoder states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NSM_S_HDR = 4'b0001,
    NSM_S_DATA = 4'b0010,
    NSM_S_EXEC = 4'b0100,
    NSM_S_RSP = 4'b1000
  } nsm_state_t;

endpackage

// *** verilog/nsm_regs.svh ***
// constants of the network-service mailbox command decoder
// assumes 16-bit mailbox words and a 16-word message header
`ifndef NSM_REGS_SVH
`define NSM_REGS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define NSM_CMD_WEB_OFF 16'h0004
`define NSM_CMD_WEB_ON 16'h0005
`define NSM_CMD_FTP_OFF 16'h0006
`define NSM_CMD_ADMIN 16'h000b
`define NSM_CMD_SMTP_GET 16'h000f
`define NSM_CMD_SMTP_NAME 16'h0016

// ----------------------------------------------------------------
// header words and their positions
// ----------------------------------------------------------------
`define NSM_INFO_CMD 16'h4002
`define NSM_INFO_RSP 16'h0002
`define NSM_INFO_ERR 16'h8002
`define NSM_FRAME_ONE 16'h0001
`define NSM_ZERO_WORD 16'h0000
`define NSM_SIZE_IP 16'h0004
`define NSM_HDR_LEN 16'h0010
`define NSM_POS_ID 16'h0000
`define NSM_POS_INFO 16'h0001
`define NSM_POS_CMD 16'h0002
`define NSM_POS_SIZE 16'h0003
`define NSM_POS_FC 16'h0004
`define NSM_POS_FN 16'h0005
`define NSM_POS_OFFH 16'h0006
`define NSM_POS_OFFL 16'h0007

`endif

// *** verilog/nsm_text_buf.sv ***
// flip-flop storage of the mail server name text, one word per entry
// assumes a synchronised reset from the parent module
`timescale 1ns/1ps

module nsm_text_buf #(
  parameter int WORDS = 64,
  parameter int AW = $clog2(WORDS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [15:0] rd_data,
  input wire logic [AW-1:0] rd2_idx,
  output logic [15:0] rd2_data
);

  logic [15:0] mem_r [WORDS];

  assign rd_data = mem_r[rd_idx];
  assign rd2_data = mem_r[rd2_idx];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        mem_r[i] <= 16'h0000;
      end
    end
    else if (wr_en)
    begin
      mem_r[wr_idx] <= wr_data;
    end
  end

endmodule
